//--- hot_swap_fault_supervisor_test.sv
/*
 Self-checking bench of the fault supervisor: register port, soft start,
 delay timers, short trip, fault latch and interrupt.
 Assumes hsfs_pkg and the load model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module hot_swap_fault_supervisor_test;
   import hsfs_pkg::*;
   logic sys_clk, rstn, en, sup, wr, rd, rd_q, power_hi, fault_n, pwr_hi, cur_hi, irq;
   logic [7:0] addr, amps, gate, prev;
   logic [31:0] wdata, rdata, e;
   logic [15:0] ptc, ctc;
   logic [31:0] expq[$];
   hsfs_cmp_t cmp;
   int n_errors, cmp_count, n;

   hsfs_supervisor DUT (.SYS_CLK(sys_clk), .RSTN(rstn), .ENABLE_PIN(en), .SUPPLY_OK_PIN(sup),
      .OVERPOWER_FLAG(cmp.overpower), .OVERCURRENT_FLAG(cmp.overcurrent),
      .BELOW_20A_FLAG(cmp.below_20a), .SHORT_FLAG(cmp.short_circuit), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .GATE_DRIVE(gate), .FAULT_N(fault_n),
      .PWR_TMR_HI(pwr_hi), .CUR_TMR_HI(cur_hi), .IRQ(irq));
   hsfs_load_model u_load (.clk(sys_clk), .gate(gate), .amps(amps), .power_hi(power_hi),
      .cmp(cmp));

   function automatic logic [31:0] st(input logic [3:0] s, input logic [1:0] c,
      input logic en_bit);
      return {24'h00_0000, 1'b1, en_bit, c, s};
   endfunction

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   // The expectation is queued first; the monitor pops it when the data stand.
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] x);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      expq.push_back(x);
      @(posedge sys_clk);
      rd <= 1'b0;
   endtask

   task automatic hold(input logic [7:0] a, input logic p, input int c);
      @(posedge sys_clk);
      amps <= a;
      power_hi <= p;
      repeat (c) @(posedge sys_clk);
   endtask

   task automatic run_load(input logic [7:0] a, input logic p, output int c);
      @(posedge sys_clk);
      amps <= a;
      power_hi <= p;
      for (c = 0; c < 5000 && fault_n === 1'b1; c++) @(negedge sys_clk);
   endtask

   task automatic power_up();
      int k;
      hold(8'h00, 1'b0, 0);
      en <= 1'b0;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK({fault_n, gate, pwr_hi, cur_hi}, 11'h400)
      @(posedge sys_clk);
      en <= 1'b1;
      prev = 8'h00;
      for (k = 0; k < 1500 && gate !== 8'hFF; k++) begin
         @(negedge sys_clk);
         `CHK(gate - prev <= 8'h01, 1'b1)
         prev = gate;
      end
      `CHK(gate, 8'hFF)
   endtask

   task automatic summarize();
      $display("errors %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge sys_clk) rd_q <= rd;
   always @(negedge sys_clk) begin
      if (rd_q) begin
         if (expq.size() == 0) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, rdata, 32'h0);
         end else begin
            e = expq.pop_front();
            `CHK(rdata, e)
         end
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // The runs take about 4000 cycles; the limit leaves ample margin.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      summarize();
   end

   initial begin
      rstn = 1'b0;
      en = 1'b0;
      sup = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      amps = 8'h00;
      power_hi = 1'b0;
      n_errors = 0;
      cmp_count = 0;
      void'($urandom(32'h0892_d647));
      ptc = 16'h0040 + 16'($urandom_range(63));
      ctc = 16'h0020 + 16'($urandom_range(31));
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      rd_reg(REG_RAMP, 32'h0000_0010);
      rd_reg(REG_PWR_TC, 32'h0000_0100);
      rd_reg(REG_CUR_TC, 32'h0000_0100);
      rd_reg(REG_IRQ_MASK, 32'h0000_0000);
      rd_reg(8'h1C, 32'h0000_0000);
      rd_reg(REG_STATUS, st(ST_OFF, CAUSE_NONE, 1'b0));
      `CHK({fault_n, gate}, 9'h100)
      wr_reg(REG_RAMP, 32'h0000_0003);
      wr_reg(REG_PWR_TC, {16'h0000, ptc});
      wr_reg(REG_CUR_TC, {16'h0000, ctc});
      wr_reg(REG_IRQ_MASK, 32'h0000_000F);
      power_up();
      rd_reg(REG_STATUS, st(ST_ON, CAUSE_NONE, 1'b1));
      `CHK(irq, 1'b1)
      rd_reg(REG_IRQ_STAT, 32'h0000_0008);
      // Each burst stays short of the trip; only clearing keeps them apart.
      hold(8'h19, 1'b1, int'(ptc) - 8);
      hold(8'h19, 1'b0, 4);
      hold(8'h19, 1'b1, int'(ptc) - 8);
      hold(8'h0F, 1'b1, 4);
      hold(8'h19, 1'b1, int'(ptc) - 8);
      `CHK(fault_n, 1'b1)
      // Let the timer clear so the trip below is timed from a zero count.
      hold(8'h19, 1'b0, 4);
      run_load(8'h19, 1'b1, n);
      `CHK(n >= ptc && n <= ptc + 4, 1'b1)
      `CHK({fault_n, gate, pwr_hi, cur_hi}, 11'h002)
      `CHK(irq, 1'b1)
      rd_reg(REG_IRQ_STAT, 32'h0000_0001);
      rd_reg(REG_IRQ_STAT, 32'h0000_0000);
      rd_reg(REG_STATUS, st(ST_FAULT, CAUSE_PWR, 1'b1));
      hold(8'h00, 1'b0, 40);
      `CHK({fault_n, gate, irq}, 10'h000)
      wr_reg(REG_IRQ_MASK, 32'h0000_0000);
      power_up();
      run_load(8'h2D, 1'b1, n);
      `CHK(n >= ctc && n <= ctc + 4, 1'b1)
      `CHK({fault_n, gate, pwr_hi, cur_hi, irq}, 12'h002)
      rd_reg(REG_IRQ_STAT, 32'h0000_000A);
      rd_reg(REG_STATUS, st(ST_FAULT, CAUSE_CUR, 1'b1));
      wr_reg(REG_CUR_TC, 32'h0000_0FFF);
      wr_reg(REG_CTRL, 32'h0000_0001);
      rd_reg(REG_CTRL, 32'h0000_0001);
      wr_reg(REG_IRQ_MASK, 32'h0000_0004);
      power_up();
      run_load(8'h96, 1'b1, n);
      `CHK(n >= SC_DELAY_CYC && n <= SC_DELAY_CYC + 4, 1'b1)
      `CHK({fault_n, gate, pwr_hi, cur_hi, irq}, 12'h001)
      rd_reg(REG_STATUS, st(ST_FAULT, CAUSE_SHORT, 1'b1));
      hold(8'h00, 1'b0, 0);
      sup <= 1'b0;
      repeat (6) @(posedge sys_clk);
      sup <= 1'b1;
      repeat (6) @(posedge sys_clk);
      `CHK({fault_n, pwr_hi, cur_hi}, 3'b100)
      repeat (3) @(posedge sys_clk);
      summarize();
   end
endmodule

//--- hsfs_delay_timer.sv
/*
 One fault delay timer: a counter that stands in for a delay capacitor.
 Assumes run and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
module hsfs_delay_timer
   import hsfs_pkg::*;
#(
   parameter int TW = TMR_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic clear,
   input wire logic [TW-1:0] tc,
   output logic [TW-1:0] count_q,
   output logic tripped_q
);
   logic at_tc;

   // A terminal count of zero trips on the first running cycle.
   assign at_tc = (count_q >= tc) || ((count_q + 1'b1) >= tc);

   // The count is dropped as soon as the condition goes away, but a
   // tripped timer keeps its level so the cause stays readable.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (clear || (!run && !tripped_q)) begin
         count_q <= '0;
      end else if (run && !tripped_q && !at_tc) begin
         count_q <= count_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tripped_q <= 1'b0;
      end else if (clear) begin
         tripped_q <= 1'b0;
      end else if (run && at_tc) begin
         tripped_q <= 1'b1;
      end
   end
endmodule

//--- hsfs_load_model.sv
/*
 Far-side model: the pass transistor, its load and the analog comparators.
 Assumes the bench sets the load current in amps and the power-over-limit
 state; flags are registered on the supervisor clock.
*/
`timescale 1ns/1ns
module hsfs_load_model
   import hsfs_pkg::*;
#(
   parameter logic [7:0] SC_AMPS = 8'h82
) (
   input wire logic clk,
   input wire logic [7:0] gate,
   input wire logic [7:0] amps,
   input wire logic power_hi,
   output hsfs_cmp_t cmp
);
   logic [7:0] flow;
   // A closed-off transistor carries nothing, so every comparator but below_20a drops with it; below_20a rises.
   assign flow = (gate == 8'h00) ? 8'h00 : amps;
   always_ff @(posedge clk) begin
      cmp.overpower <= power_hi && (flow != 8'h00);
      cmp.overcurrent <= flow >= 8'h28;
      cmp.below_20a <= flow < 8'h14;
      cmp.short_circuit <= flow >= SC_AMPS;
   end
endmodule

//--- hsfs_pkg.sv
/*
 Shared constants and types of the hot-swap fault supervisor.
 Assumes a single 125 MHz system clock domain.
*/
package hsfs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int TMR_W = 16;
   localparam int GATE_W = 8;
   localparam int IRQ_W = 4;
   // Register byte offsets.
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_RAMP = 8'h04;
   localparam logic [ADDR_W-1:0] REG_PWR_TC = 8'h08;
   localparam logic [ADDR_W-1:0] REG_CUR_TC = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h18;
   // Field positions.
   localparam int CTRL_CUR_MODE = 0;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_CAUSE_LSB = 4;
   localparam int STAT_EN_BIT = 6;
   localparam int STAT_SUP_BIT = 7;
   localparam int IRQ_PWR_TRIP = 0;
   localparam int IRQ_CUR_TRIP = 1;
   localparam int IRQ_SHORT_TRIP = 2;
   localparam int IRQ_RAMP_DONE = 3;
   // Reset values.
   localparam logic [TMR_W-1:0] RAMP_RST = 16'h0010;
   localparam logic [TMR_W-1:0] TC_RST = 16'h0100;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
   // Short-circuit reaction time.
   localparam int CLK_PERIOD_NS = 8;
   localparam int SC_DELAY_NS = 2000;
   localparam int SC_DELAY_CYC = SC_DELAY_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic overpower;
      logic overcurrent;
      logic below_20a;
      logic short_circuit;
   } hsfs_cmp_t;

   typedef enum logic [3:0] {
      ST_OFF = 4'b0001,
      ST_RAMP = 4'b0010,
      ST_ON = 4'b0100,
      ST_FAULT = 4'b1000
   } hsfs_state_t;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'h0,
      CAUSE_PWR = 2'h1,
      CAUSE_CUR = 2'h2,
      CAUSE_SHORT = 2'h3
   } hsfs_cause_t;
endpackage

//--- hsfs_supervisor.sv
/*
 Fault supervisor of a high-side hot-swap monitor: soft-start of the pass
 transistor drive, power and current delay timers, short-circuit trip,
 latched active-low fault, register port and interrupt.
 Assumes comparator flags are synchronous to SYS_CLK; the enable and
 supply pins are asynchronous and are synchronised here.
*/
// Notes on behaviour
// - While the switch-on request is low the drive output is held at zero.
// - After the request rises the drive ramps up one step per ramp period.
// - The switch-on request is active high and the trip flag active low.
// - Overpower advances the power timer and its terminal count trips a fault.
// - Overpower going away before the trip clears the power timer.
// - The timers run at once (the power timer only with CTRL_CUR_MODE clear) and the first one to trip latches the fault.
// - The power timer clears below 20 A and the current timer below 40 A.
// - Both timers advance one count per clock, so only the terminal count sets delay.
// - On a fault the trip flag goes low and the drive goes to zero together.
// - A fault stays latched with the drive at zero until the request cycles.
// - A low request clears the fault, both timers and the soft-start state.
// - A short circuit held for about 2 us forces the drive off.
// - After a fault the timer outputs show the cause.
// - Losing and restoring the supply also clears a latched fault.
`timescale 1ns/1ns
module hsfs_supervisor
   import hsfs_pkg::*;
#(
   parameter int GW = GATE_W,
   parameter int TW = TMR_W
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic ENABLE_PIN,
   input wire logic SUPPLY_OK_PIN,
   input wire logic OVERPOWER_FLAG,
   input wire logic OVERCURRENT_FLAG,
   input wire logic BELOW_20A_FLAG,
   input wire logic SHORT_FLAG,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DATA_W-1:0] RDATA,
   output logic [GW-1:0] GATE_DRIVE,
   output logic FAULT_N,
   output logic PWR_TMR_HI,
   output logic CUR_TMR_HI,
   output logic IRQ
);
   localparam logic [GW-1:0] GATE_MAX = {GW{1'b1}};
   localparam logic [8:0] SC_LAST = 9'(SC_DELAY_CYC - 1);

   hsfs_cmp_t cmp;
   hsfs_state_t state_q, state_d;
   hsfs_cause_t cause_q;
   logic [1:0] en_sync_q, sup_sync_q;
   logic en_req;
   logic cur_mode_q;
   logic [TW-1:0] ramp_rate_q, pwr_tc_q, cur_tc_q, pres_q;
   logic [GW-1:0] gate_q;
   logic [8:0] sc_cnt_q;
   logic sc_trip, running, trip;
   logic [IRQ_W-1:0] ist_q, ist_d, imask_q, ev;
   logic [DATA_W-1:0] rdata_q;
   logic fault_n_q, irq_q;
   logic [1:0] tmr_run, tmr_trip;
   logic [TW-1:0] tmr_tc [2];
   logic [TW-1:0] tmr_cnt [2];

   assign cmp = '{overpower: OVERPOWER_FLAG, overcurrent: OVERCURRENT_FLAG,
                  below_20a: BELOW_20A_FLAG, short_circuit: SHORT_FLAG};

   // Only the second flop of each synchroniser is read by logic.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         en_sync_q <= 2'b00;
         sup_sync_q <= 2'b00;
      end else begin
         en_sync_q <= {en_sync_q[0], ENABLE_PIN};
         sup_sync_q <= {sup_sync_q[0], SUPPLY_OK_PIN};
      end
   end

   // The request counts only while the supply is present.
   assign en_req = en_sync_q[1] && sup_sync_q[1];

   assign running = (state_q == ST_RAMP) || (state_q == ST_ON);

   // Both timers count one step per clock while their condition holds.
   assign tmr_run[0] = running && en_req && cmp.overpower && !cmp.below_20a
                       && !cur_mode_q;
   assign tmr_run[1] = running && en_req && cmp.overcurrent;
   assign tmr_tc[0] = pwr_tc_q;
   assign tmr_tc[1] = cur_tc_q;

   generate
      for (genvar i = 0; i < 2; i++) begin : g_tmr
         hsfs_delay_timer #(
            .TW(TW)
         ) u_tmr (
            .clk(SYS_CLK),
            .rst_n(RSTN),
            .run(tmr_run[i]),
            .clear(!en_req),
            .tc(tmr_tc[i]),
            .count_q(tmr_cnt[i]),
            .tripped_q(tmr_trip[i])
         );
      end
   endgenerate

   // Timer outputs are the tripped levels, so they read low after a short.
   assign PWR_TMR_HI = tmr_trip[0];
   assign CUR_TMR_HI = tmr_trip[1];

   // Short-circuit delay counter; it restarts if the flag drops early.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         sc_cnt_q <= '0;
      end else if (!running || !cmp.short_circuit || !en_req) begin
         sc_cnt_q <= '0;
      end else if (sc_cnt_q != SC_LAST) begin
         sc_cnt_q <= sc_cnt_q + 1'b1;
      end
   end

   assign sc_trip = running && cmp.short_circuit && (sc_cnt_q == SC_LAST);
   assign trip = running && en_req && (sc_trip || (|tmr_trip));

   always_comb begin
      state_d = state_q;
      if (!en_req) begin
         state_d = ST_OFF;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               state_d = ST_RAMP;
            end
            ST_RAMP: begin
               if (trip) begin
                  state_d = ST_FAULT;
               end else if (gate_q == GATE_MAX) begin
                  state_d = ST_ON;
               end
            end
            ST_ON: begin
               if (trip) begin
                  state_d = ST_FAULT;
               end
            end
            ST_FAULT: begin
               state_d = ST_FAULT;
            end
            default: begin
               state_d = ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // The trip flag is registered from the next state so it falls on the
   // same edge that zeroes the drive.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         fault_n_q <= 1'b1;
      end else begin
         fault_n_q <= (state_d != ST_FAULT);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cause_q <= CAUSE_NONE;
      end else if (!en_req) begin
         cause_q <= CAUSE_NONE;
      end else if (trip && (state_q != ST_FAULT)) begin
         if (tmr_trip[0]) begin
            cause_q <= CAUSE_PWR;
         end else if (tmr_trip[1]) begin
            cause_q <= CAUSE_CUR;
         end else begin
            cause_q <= CAUSE_SHORT;
         end
      end
   end

   // Soft-start prescaler: one drive step per ramp_rate_q + 1 clocks.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pres_q <= '0;
      end else if (state_d != ST_RAMP || pres_q >= ramp_rate_q) begin
         pres_q <= '0;
      end else begin
         pres_q <= pres_q + 1'b1;
      end
   end

   // A large ramp period trades startup time for lower inrush.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         gate_q <= '0;
      end else if (state_d == ST_OFF || state_d == ST_FAULT) begin
         gate_q <= '0;
      end else if (state_q == ST_RAMP && pres_q >= ramp_rate_q
                   && gate_q != GATE_MAX) begin
         gate_q <= gate_q + 1'b1;
      end
   end

   assign GATE_DRIVE = gate_q;
   assign FAULT_N = fault_n_q;

   // Register writes.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cur_mode_q <= 1'b0;
         ramp_rate_q <= RAMP_RST;
         pwr_tc_q <= TC_RST;
         cur_tc_q <= TC_RST;
         imask_q <= IRQ_MASK_RST;
      end else if (WR) begin
         unique case (ADDR)
            REG_CTRL: cur_mode_q <= WDATA[CTRL_CUR_MODE];
            REG_RAMP: ramp_rate_q <= WDATA[TW-1:0];
            REG_PWR_TC: pwr_tc_q <= WDATA[TW-1:0];
            REG_CUR_TC: cur_tc_q <= WDATA[TW-1:0];
            REG_IRQ_MASK: imask_q <= WDATA[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Interrupt events; a new event wins over the read that clears.
   always_comb begin
      ev = '0;
      ev[IRQ_PWR_TRIP] = trip && (state_q != ST_FAULT) && tmr_trip[0];
      ev[IRQ_CUR_TRIP] = trip && (state_q != ST_FAULT) && !tmr_trip[0]
                         && tmr_trip[1];
      ev[IRQ_SHORT_TRIP] = trip && (state_q != ST_FAULT) && !(|tmr_trip);
      ev[IRQ_RAMP_DONE] = (state_q == ST_RAMP) && (state_d == ST_ON);
      ist_d = ist_q;
      if (RD && ADDR == REG_IRQ_STAT) begin
         ist_d = '0;
      end
      ist_d = ist_d | ev;
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ist_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ist_q <= ist_d;
         irq_q <= |(ist_d & imask_q);
      end
   end

   assign IRQ = irq_q;

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= '0;
         if (RD) begin
            unique case (ADDR)
               REG_CTRL: rdata_q[CTRL_CUR_MODE] <= cur_mode_q;
               REG_RAMP: rdata_q[TW-1:0] <= ramp_rate_q;
               REG_PWR_TC: rdata_q[TW-1:0] <= pwr_tc_q;
               REG_CUR_TC: rdata_q[TW-1:0] <= cur_tc_q;
               REG_STATUS: begin
                  rdata_q[STAT_STATE_LSB +: 4] <= state_q;
                  rdata_q[STAT_CAUSE_LSB +: 2] <= cause_q;
                  rdata_q[STAT_EN_BIT] <= en_sync_q[1];
                  rdata_q[STAT_SUP_BIT] <= sup_sync_q[1];
               end
               REG_IRQ_STAT: rdata_q[IRQ_W-1:0] <= ist_q;
               REG_IRQ_MASK: rdata_q[IRQ_W-1:0] <= imask_q;
               default: begin
               end
            endcase
         end
      end
   end

   assign RDATA = rdata_q;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   property p_off_drive_low;
      !en_req |=> (gate_q == '0);
   endproperty
   a_off_drive_low: assert property (p_off_drive_low)
      else $error("drive not zero while request low");

   property p_ramp_step;
      (gate_q != $past(gate_q)) && (gate_q != '0) |->
         (gate_q == $past(gate_q) + 1'b1) && $past(pres_q) >= $past(ramp_rate_q);
   endproperty
   a_ramp_step: assert property (p_ramp_step)
      else $error("drive rose by more than one step or early");

   property p_pwr_trip;
      running && en_req && tmr_trip[0] |=> !fault_n_q ##1 PWR_TMR_HI;
   endproperty
   a_pwr_trip: assert property (p_pwr_trip)
      else $error("power timer trip did not latch the fault");

   property p_timer_clear;
      !tmr_run[0] && !tmr_trip[0] |=> (tmr_cnt[0] == '0);
   endproperty
   a_timer_clear: assert property (p_timer_clear)
      else $error("power timer not cleared");

   property p_equal_rate;
      tmr_run[1] && !tmr_trip[1] && (tmr_cnt[1] + 1'b1 < cur_tc_q) |=>
         (tmr_cnt[1] == $past(tmr_cnt[1]) + 1'b1);
   endproperty
   a_equal_rate: assert property (p_equal_rate)
      else $error("current timer did not advance by one");

   property p_fault_drive_off;
      !fault_n_q |-> (gate_q == '0) && (state_q == ST_FAULT);
   endproperty
   a_fault_drive_off: assert property (p_fault_drive_off)
      else $error("fault flag low with drive on");

   property p_fault_held;
      !fault_n_q && en_req |=> !fault_n_q;
   endproperty
   a_fault_held: assert property (p_fault_held)
      else $error("fault released while request high");

   property p_request_low_resets;
      !en_req |=> fault_n_q && !PWR_TMR_HI && !CUR_TMR_HI && (state_q == ST_OFF);
   endproperty
   a_request_low_resets: assert property (p_request_low_resets)
      else $error("request low did not reset supervisor");

   property p_short_delay;
      running && en_req && cmp.short_circuit && (sc_cnt_q == SC_LAST) |=>
         !fault_n_q && (gate_q == '0);
   endproperty
   a_short_delay: assert property (p_short_delay)
      else $error("short circuit did not force drive off");

   property p_short_cause;
      !fault_n_q && (cause_q == CAUSE_SHORT) |-> !PWR_TMR_HI && !CUR_TMR_HI;
   endproperty
   a_short_cause: assert property (p_short_cause)
      else $error("timer outputs wrong after short circuit");

   c_pwr_fault: cover property (ev[IRQ_PWR_TRIP] ##1 !fault_n_q);
   c_short_fault: cover property (ev[IRQ_SHORT_TRIP] ##1 !fault_n_q);
   c_ramp_done: cover property (state_q == ST_RAMP ##1 state_q == ST_ON);
endmodule
